/* hdl/rrg_pkg.sv */
// package of constants and types for the resume reset generator
package rrg_pkg;
   // ==================================================
   // clock and timing
   // ==================================================
   localparam int unsigned CLK_HZ            = 20000000;
   localparam int unsigned NOMINAL_DELAY_MS  = 32;   // prose figure, kept for reference
   localparam int unsigned DELAY_MIN_MS      = 140;
   localparam int unsigned DELAY_TYP_MS      = 350;
   localparam int unsigned DELAY_MAX_MS      = 560;
   localparam int unsigned ASSERT_MAX_NS     = 100;
   localparam int unsigned CLK_PERIOD_NS     = 1000000000 / CLK_HZ;
   // longest time rounds down, never below one cycle
   localparam int unsigned ASSERT_CYCLES     =
      (ASSERT_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : ASSERT_MAX_NS / CLK_PERIOD_NS;
   // typical release delay in cycles; 64-bit math to avoid overflow
   localparam longint unsigned DELAY_TYP_CYCLES =
      (64'(DELAY_TYP_MS) * 64'(CLK_HZ)) / 64'd1000;
   localparam int unsigned CNT_W             = 24;
   localparam bit          RESET_OUT_VAL     = 1'b0;

   // ==================================================
   // types
   // ==================================================
   typedef enum logic [1:0] {
      RRG_HOLD,
      RRG_DELAY,
      RRG_RUN
   } rrg_state_t;

   typedef struct packed {
      logic resume_reset_n;
      logic delay_running;
   } rrg_status_t;
endpackage

/* hdl/rrg_resume_reset.sv */
// resume well reset generator driven by the standby supply comparator
`timescale 1ns/1ps
module rrg_resume_reset #(
   parameter int unsigned RELEASE_CYCLES = 32'(rrg_pkg::DELAY_TYP_CYCLES)
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 supply_above_trip_i,
   output rrg_pkg::rrg_status_t      status_o
);
   // ==================================================
   // comparator synchroniser
   // ==================================================
   logic sync_meta;
   logic sync_ok;

   // only the trip comparator feeds the logic
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_meta <= 1'b0;
         sync_ok   <= 1'b0;
      end else begin
         sync_meta <= supply_above_trip_i;
         sync_ok   <= sync_meta;
      end
   end

   // ==================================================
   // release delay counter and state
   // ==================================================
   // the counter width caps the delay at 2**CNT_W cycles;
   // a longer RELEASE_CYCLES needs a wider CNT_W in the package
   localparam int unsigned               LAST_INT = RELEASE_CYCLES - 1;
   localparam logic [rrg_pkg::CNT_W-1:0] LAST_CNT = LAST_INT[rrg_pkg::CNT_W-1:0];
   localparam logic [rrg_pkg::CNT_W-1:0] CNT_ONE  = {{(rrg_pkg::CNT_W-1){1'b0}}, 1'b1};

   rrg_pkg::rrg_state_t         state;
   rrg_pkg::rrg_state_t         next_state;
   logic [rrg_pkg::CNT_W-1:0]   cnt;
   logic [rrg_pkg::CNT_W-1:0]   next_cnt;
   logic                        next_reset_n;
   wire                         cnt_done = (cnt == LAST_CNT);
   // raw level gates release
   // the raw level is ANDed with sync_ok, so it can only keep the output low;
   // waiting on the synchroniser alone takes three clocks, over 100 ns
   wire                         supply_ok = sync_ok & supply_above_trip_i;

   // next-state decode; a supply loss always wins
   always_comb begin
      next_state   = state;
      next_cnt     = '0;
      next_reset_n = 1'b0;
      unique case (state)
         rrg_pkg::RRG_HOLD: begin
            if (supply_ok) begin
               next_state = rrg_pkg::RRG_DELAY;
            end
         end
         rrg_pkg::RRG_DELAY: begin
            if (!supply_ok) begin
               next_state = rrg_pkg::RRG_HOLD;
            end else if (cnt_done) begin
               next_state   = rrg_pkg::RRG_RUN;
               next_reset_n = 1'b1;
            end else begin
               next_cnt = cnt + CNT_ONE;
            end
         end
         rrg_pkg::RRG_RUN: begin
            if (!supply_ok) begin
               next_state = rrg_pkg::RRG_HOLD;
            end else begin
               next_reset_n = 1'b1;
            end
         end
         default: next_state = rrg_pkg::RRG_HOLD;
      endcase
   end

   // state registers; output straight from a flop
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state    <= rrg_pkg::RRG_HOLD;
         cnt      <= '0;
         status_o <= '{resume_reset_n: rrg_pkg::RESET_OUT_VAL, delay_running: 1'b0};
      end else begin
         state                   <= next_state;
         cnt                     <= next_cnt;
         status_o.resume_reset_n <= next_reset_n;
         status_o.delay_running  <= (next_state == rrg_pkg::RRG_DELAY);
      end
   end

   // ==================================================
   // assertions
   // ==================================================
   // cycles since synchronised supply last seen high continuously
   logic [rrg_pkg::CNT_W-1:0] good_run;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         good_run <= '0;
      end else if (!sync_ok) begin
         good_run <= '0;
      end else if (good_run != '1) begin
         good_run <= good_run + CNT_ONE;
      end
   end

   a_no_early_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.resume_reset_n) |-> good_run >= LAST_CNT)
      else $error("reset released before release delay");

   a_fast_assert: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !supply_above_trip_i |=> !status_o.resume_reset_n)
      else $error("reset not reasserted after supply loss");

   a_dip_clears: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !sync_ok |=> cnt == '0 && !status_o.delay_running)
      else $error("delay counter not cleared on supply dip");

   a_delay_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(sync_ok) && supply_above_trip_i |=> status_o.delay_running)
      else $error("release delay did not start");

   a_sync_path: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(supply_above_trip_i) ##1 supply_above_trip_i |=> sync_ok)
      else $error("comparator not synchronised in two cycles");

   a_release_exact: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      supply_ok && state == rrg_pkg::RRG_DELAY && cnt_done |=> status_o.resume_reset_n)
      else $error("reset not released when delay elapsed");

   a_low_in_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == rrg_pkg::RRG_HOLD |-> !status_o.resume_reset_n)
      else $error("reset high while holding");

   a_stays_released: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_o.resume_reset_n && supply_ok |=> status_o.resume_reset_n)
      else $error("reset dropped without supply loss");

   a_dip_no_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !sync_ok |=> !status_o.resume_reset_n)
      else $error("reset released while supply low");

   a_outputs_exclusive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      status_o.delay_running |-> !status_o.resume_reset_n)
      else $error("delay flag and release seen together");

   a_run_released: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == rrg_pkg::RRG_RUN |-> status_o.resume_reset_n)
      else $error("reset low in run state");

   a_release_needs_supply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.resume_reset_n) |-> $past(sync_ok))
      else $error("reset released with supply below threshold");

   a_delay_from_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.delay_running) |-> $past(state) == rrg_pkg::RRG_HOLD)
      else $error("release delay started outside hold");

   a_cnt_in_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      cnt <= LAST_CNT)
      else $error("delay counter past its end value");

   a_cnt_steps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == rrg_pkg::RRG_DELAY && supply_ok && !cnt_done |=> cnt == $past(cnt) + CNT_ONE)
      else $error("delay counter did not advance");

   a_hold_no_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      state == rrg_pkg::RRG_HOLD |-> cnt == '0)
      else $error("delay counter not zero while holding");

   a_sync_fall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $fell(supply_above_trip_i) |=> ##1 !sync_ok)
      else $error("comparator fall not synchronised in two cycles");

   // ==================================================
   // check helpers
   // ==================================================
   // cycles the delay flag has stood high without a break
   logic [rrg_pkg::CNT_W-1:0] delay_len;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         delay_len <= '0;
      end else if (status_o.delay_running) begin
         delay_len <= delay_len + CNT_ONE;
      end else begin
         delay_len <= '0;
      end
   end

   a_full_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $rose(status_o.resume_reset_n) |-> delay_len == LAST_CNT + CNT_ONE)
      else $error("release did not follow one unbroken delay");
endmodule

/* sim/rrg_chipset_model.sv */
// chipset resume well reset input model
`timescale 1ns/1ps
module rrg_chipset_model (
   input  wire logic resume_reset_n_i,
   output int        releases_o
);
   // ==========================
   // reset input
   // ==========================
   // counts each release of the resume well out of reset;
   // one process keeps a single driver on the count
   initial begin
      releases_o = 0;
      forever begin
         @(posedge resume_reset_n_i);
         releases_o = releases_o + 1;
      end
   end
endmodule

/* sim/rrg_resume_reset_tb.sv */
// self-checking bench for the resume reset generator
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
   $display("BAD %0t mismatch got %0d want %0d", $time, got, exp); end end
module rrg_resume_reset_tb;
   // short delay keeps the run brief
   localparam int unsigned N = 20;
   logic                 clk_i               = 1'b0;
   logic                 rst_n_i             = 1'b0;
   logic                 supply_above_trip_i = 1'b0;
   rrg_pkg::rrg_status_t status_o;
   int                   releases;
   int                   bad_count           = 0;
   int                   samples_checked     = 0;
   int                   cyc;
   initial forever #25 clk_i = ~clk_i;
   rrg_resume_reset #(.RELEASE_CYCLES(N)) u_rrg_resume_reset (
      .clk_i               (clk_i),
      .rst_n_i             (rst_n_i),
      .supply_above_trip_i (supply_above_trip_i),
      .status_o            (status_o)
   );
   rrg_chipset_model u_rrg_chipset_model (
      .resume_reset_n_i (status_o.resume_reset_n),
      .releases_o       (releases)
   );
   task automatic tally_and_finish;
      $display("checks %0d bad %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // inputs change on the falling edge only
   task automatic set_supply(input logic v);
      @(negedge clk_i) supply_above_trip_i = v;
   endtask
   // bounded wait for the reset output to reach a level
   task automatic wait_out(input logic v, input int max);
      cyc = 0;
      while (status_o.resume_reset_n !== v && cyc < max) begin
         @(posedge clk_i);
         #1 cyc++;
      end
      if (status_o.resume_reset_n !== v) begin
         bad_count++;
         $display("BAD %0t reset output never changed", $time);
         tally_and_finish();
      end
   endtask
   task automatic t_release;
      set_supply(1'b1);
      repeat (6) @(posedge clk_i);
      #1;
      `CHECK(status_o.delay_running, 1'b1)
      `CHECK(status_o.resume_reset_n, 1'b0)
      wait_out(1'b1, N + 8);
      `CHECK(cyc + 6 inside {[N + 3:N + 5]}, 1'b1)
      `CHECK(releases, 1)
   endtask
   task automatic t_fall;
      set_supply(1'b0);
      wait_out(1'b0, 3);
      `CHECK(cyc <= int'(rrg_pkg::ASSERT_CYCLES), 1'b1)
      `CHECK(status_o.delay_running, 1'b0)
   endtask
   // supply dip mid-delay must restart the whole count
   task automatic t_dip;
      set_supply(1'b1);
      repeat (12) @(posedge clk_i);
      set_supply(1'b0);
      repeat (4) @(posedge clk_i);
      #1;
      `CHECK(status_o, 2'b00)
      set_supply(1'b1);
      wait_out(1'b1, N + 8);
      `CHECK(cyc inside {[N + 3:N + 5]}, 1'b1)
      `CHECK(releases, 2)
   endtask
   // reset in mid-run drops the output at once and restarts the delay
   task automatic t_reset_mid;
      @(negedge clk_i) rst_n_i = 1'b0;
      #1;
      `CHECK(status_o, 2'b00)
      repeat (3) @(posedge clk_i);
      @(negedge clk_i) rst_n_i = 1'b1;
      wait_out(1'b1, N + 8);
      `CHECK(cyc inside {[N + 3:N + 5]}, 1'b1)
      `CHECK(releases, 3)
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      #1;
      `CHECK(status_o, 2'b00)
      @(negedge clk_i) rst_n_i = 1'b1;
      repeat (3) @(posedge clk_i);
      t_release();
      t_fall();
      t_dip();
      t_reset_mid();
      t_fall();
      tally_and_finish();
   end
endmodule
